// ---- rtl/ast_pkg.sv ----
// Package for the asynchronous serial transceiver: register map,
// field positions, reset values, baud timing and the state record.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
`default_nettype none
package ast_pkg;
   // Clocks and baud timing
   localparam int CORE_HZ = 10_000_000;
   localparam int RC_REF_HZ = 2_457_600;
   localparam int RC_TICK_DIV = CORE_HZ / RC_REF_HZ;
   localparam int RC_FAST_BAUD = 153_600;
   localparam int RC_TICKS_FAST = RC_REF_HZ / RC_FAST_BAUD;
   localparam int XTAL_HZ = 32_768;
   localparam int XTAL_FAST_BAUD = 2400;
   // Rounds up to 14: the source of the fixed -2.48 % rate error
   localparam int XTAL_DIV = (XTAL_HZ + XTAL_FAST_BAUD - 1) / XTAL_FAST_BAUD;
   localparam logic [2:0] XTAL_TOP_RATE = 3'h3;
   // Register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_TXD = 8'h08;
   localparam logic [7:0] OFF_TXS = 8'h0c;
   localparam logic [7:0] OFF_RXD = 8'h10;
   localparam logic [7:0] OFF_RXS = 8'h14;
   localparam logic [5:0] LAST_INDEX = 6'h05;
   // serial_command_reg fields
   localparam int CMD_XTAL = 7;
   localparam int CMD_RCSEL = 3;
   localparam int CMD_PM = 2;
   localparam int CMD_PE = 1;
   localparam int CMD_WL = 0;
   localparam logic [7:0] CMD_RST = 8'h01;
   localparam logic [7:0] CMD_MASK = 8'hbf;
   // serial_control_reg fields
   localparam int CTL_ECHO = 7;
   localparam int CTL_ENRX = 6;
   localparam int CTL_ENTX = 5;
   localparam int CTL_XRX = 4;
   localparam int CTL_XTX = 3;
   localparam int CTL_BR = 0;
   localparam logic [7:0] CTRL_RST = 8'h05;
   // Status fields
   localparam int TXS_FULL = 0;
   localparam int TXS_BUSY = 1;
   localparam int RXS_FULL = 0;
   localparam int RXS_BUSY = 1;
   localparam int RXS_OERR = 2;
   localparam int RXS_FERR = 3;
   localparam int RXS_PERR = 4;
   localparam int RXS_SERR = 5;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} ast_rx_state_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] ctrl;
      logic [7:0] tx_data;
      logic tx_full;
      logic tx_busy;
      logic [10:0] tx_shift;
      logic [3:0] tx_bits;
      logic [11:0] tx_cnt;
      logic tx_pin;
      logic irq_tx;
      ast_rx_state_t rx_state;
      logic [8:0] rx_shift;
      logic [3:0] rx_bits;
      logic [11:0] rx_cnt;
      logic [7:0] rx_data;
      logic rx_full;
      logic s_err;
      logic p_err;
      logic f_err;
      logic o_err;
      logic s_seen;
      logic irq_rx;
      logic [2:0] tick_div;
      logic xtal_last;
      logic [31:0] prdata;
      logic [1:0] rx_sync;
      logic [1:0] xtal_sync;
   } ast_state_t;

   localparam ast_state_t ST_RST = '{cmd: CMD_RST, ctrl: CTRL_RST, tx_pin: 1'b1,
      rx_state: RX_IDLE, rx_sync: 2'b11, default: '0};
endpackage
`default_nettype wire

// ---- rtl/ast_uart.sv ----
// Asynchronous serial transceiver with an APB register port.
// Assumes a 10 MHz core_clk; rx_pin and xtal_clk are asynchronous pins.
//
// What this block does
// - Crystal rate field 011/010/001/000 gives 2400/1200/600/300 baud.
// - Crystal baud rates run 2.48 percent slow from integer division.
// - Separate receive and transmit enables switch each direction.
// - Word length is seven or eight data bits.
// - Parity appended on transmit and checked on receive when enabled.
// - Parity mode 1 odd, 0 even; enable 1 adds parity; length 1 eight.
// - Invert bits flip the incoming and outgoing line.
// - Echo drives transmit pin with receive pin XOR both invert bits.
// - Writing transmit data sets the transmit-full flag.
// - After previous word ends, data loads into shifter, full flag clears.
// - Transmit interrupt pulses when the full flag falls.
// - Transmit-busy stays high while a word shifts out.
// - Data bits go out least significant bit first.
// - Start bit detection sets receive-busy.
// - At stop bit, data moves to register, full set, interrupt raised.
// - Reading data clears full; new word before read sets overrun.
// - Overrun holds until software writes the receive status register.
// - Start error flag is updated at each transfer to receive data.
// - Parity error flag is updated at each transfer to receive data.
// - Frame error flag set when stop bit is not high.
`default_nettype none
module ast_uart (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   input wire logic xtal_clk,
   output logic tx_pin,
   output logic irq_tx,
   output logic irq_rx
);
   ast_pkg::ast_state_t s;
   ast_pkg::ast_state_t next_s;

   logic mapped;
   logic wr;
   logic rd;
   logic wr_txd;
   logic wr_rxs;
   logic rd_rxd;
   logic tick;
   logic [11:0] bit_len;
   logic line;
   logic [2:0] br;

   assign br = s.ctrl[ast_pkg::CTL_BR +: 3];
   assign mapped = (paddr[1:0] == 2'b00) && (paddr[7:2] <= ast_pkg::LAST_INDEX);
   assign wr = psel && penable && pwrite && mapped;
   assign rd = psel && penable && !pwrite && mapped;
   assign wr_txd = wr && (paddr == ast_pkg::OFF_TXD);
   assign wr_rxs = wr && (paddr == ast_pkg::OFF_RXS);
   assign rd_rxd = rd && (paddr == ast_pkg::OFF_RXD);
   assign line = s.rx_sync[1] ^ s.ctrl[ast_pkg::CTL_XRX];

   // Baud tick source and ticks per bit
   always_comb begin
      if (s.cmd[ast_pkg::CMD_XTAL]) begin
         tick = s.xtal_sync[1] && !s.xtal_last;
         if (br > ast_pkg::XTAL_TOP_RATE) begin
            bit_len = 12'(ast_pkg::XTAL_DIV);
         end else begin
            bit_len = 12'(ast_pkg::XTAL_DIV) << (ast_pkg::XTAL_TOP_RATE - br);
         end
      end else begin
         tick = (s.tick_div == 3'(ast_pkg::RC_TICK_DIV - 1));
         bit_len = 12'(ast_pkg::RC_TICKS_FAST) << (3'h7 - br);
      end
   end

   always_comb begin
      logic wl;
      logic pe;
      logic pm;
      logic [7:0] d8;
      logic [10:0] frame;
      logic [8:0] al;
      logic [7:0] rdat;
      logic rpar;
      logic [3:0] nb;
      wl = s.cmd[ast_pkg::CMD_WL];
      pe = s.cmd[ast_pkg::CMD_PE];
      pm = s.cmd[ast_pkg::CMD_PM];
      d8 = wl ? s.tx_data : {1'b0, s.tx_data[6:0]};
      frame = '1;
      al = '0;
      rdat = '0;
      rpar = 1'b0;
      nb = {3'b000, pe} + (wl ? 4'h8 : 4'h7);
      next_s = s;
      next_s.irq_tx = 1'b0;
      next_s.irq_rx = 1'b0;
      next_s.rx_sync = {s.rx_sync[0], rx_pin};
      next_s.xtal_sync = {s.xtal_sync[0], xtal_clk};
      next_s.xtal_last = s.xtal_sync[1];
      next_s.tick_div = tick ? 3'h0 : s.tick_div + 3'h1;

      // Register writes
      if (wr) begin
         unique case (paddr)
            ast_pkg::OFF_CMD: next_s.cmd = pwdata[7:0] & ast_pkg::CMD_MASK;
            ast_pkg::OFF_CTRL: next_s.ctrl = pwdata[7:0];
            ast_pkg::OFF_TXD: next_s.tx_data = pwdata[7:0];
            default: ;
         endcase
      end

      // Transmitter
      if (!s.ctrl[ast_pkg::CTL_ENTX]) begin
         next_s.tx_busy = 1'b0;
      end else if (s.tx_busy) begin
         if (tick) begin
            next_s.tx_cnt = s.tx_cnt + 12'h1;
            if (s.tx_cnt == bit_len - 12'h1) begin
               next_s.tx_cnt = '0;
               if (s.tx_bits == 4'h0) begin
                  next_s.tx_busy = 1'b0;
               end else begin
                  next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
                  next_s.tx_bits = s.tx_bits - 4'h1;
               end
            end
         end
      end else if (s.tx_full) begin
         // Frame: start low, data LSB first, parity, stop high
         if (pe) begin
            if (wl) begin
               frame = {1'b1, ^d8 ^ pm, d8, 1'b0};
            end else begin
               frame = {2'b11, ^d8 ^ pm, d8[6:0], 1'b0};
            end
         end else if (wl) begin
            frame = {2'b11, d8, 1'b0};
         end else begin
            frame = {3'b111, d8[6:0], 1'b0};
         end
         next_s.tx_shift = frame;
         next_s.tx_bits = nb + 4'h1;
         next_s.tx_cnt = '0;
         next_s.tx_busy = 1'b1;
         next_s.tx_full = 1'b0;
         next_s.irq_tx = 1'b1;
      end
      if (wr_txd) begin
         next_s.tx_full = 1'b1;
      end

      // Transmit pin, registered
      if (s.ctrl[ast_pkg::CTL_ECHO]) begin
         next_s.tx_pin = s.rx_sync[1] ^ s.ctrl[ast_pkg::CTL_XRX] ^ s.ctrl[ast_pkg::CTL_XTX];
      end else begin
         next_s.tx_pin = (next_s.tx_busy ? next_s.tx_shift[0] : 1'b1)
            ^ s.ctrl[ast_pkg::CTL_XTX];
      end

      // Receiver
      if (rd_rxd) begin
         next_s.rx_full = 1'b0;
      end
      if (wr_rxs) begin
         next_s.o_err = 1'b0;
      end
      if (!s.ctrl[ast_pkg::CTL_ENRX]) begin
         next_s.rx_state = ast_pkg::RX_IDLE;
      end else begin
         unique case (s.rx_state)
            ast_pkg::RX_IDLE: begin
               if (!line) begin
                  next_s.rx_state = ast_pkg::RX_START;
                  next_s.rx_cnt = '0;
               end
            end
            ast_pkg::RX_START: begin
               if (tick) begin
                  next_s.rx_cnt = s.rx_cnt + 12'h1;
                  if (s.rx_cnt == (bit_len >> 1) - 12'h1) begin
                     next_s.s_seen = line;
                     next_s.rx_cnt = '0;
                     next_s.rx_bits = nb - 4'h1;
                     next_s.rx_state = ast_pkg::RX_BITS;
                  end
               end
            end
            ast_pkg::RX_BITS: begin
               if (tick) begin
                  next_s.rx_cnt = s.rx_cnt + 12'h1;
                  if (s.rx_cnt == bit_len - 12'h1) begin
                     next_s.rx_cnt = '0;
                     next_s.rx_shift = {line, s.rx_shift[8:1]};
                     next_s.rx_bits = s.rx_bits - 4'h1;
                     if (s.rx_bits == 4'h0) begin
                        next_s.rx_state = ast_pkg::RX_STOP;
                     end
                  end
               end
            end
            ast_pkg::RX_STOP: begin
               if (tick) begin
                  next_s.rx_cnt = s.rx_cnt + 12'h1;
                  if (s.rx_cnt == bit_len - 12'h1) begin
                     al = s.rx_shift >> (4'h9 - nb);
                     rdat = wl ? al[7:0] : {1'b0, al[6:0]};
                     rpar = wl ? al[8] : al[7];
                     next_s.rx_state = ast_pkg::RX_IDLE;
                     next_s.rx_data = rdat;
                     next_s.rx_full = 1'b1;
                     next_s.irq_rx = 1'b1;
                     next_s.o_err = next_s.o_err || (s.rx_full && !rd_rxd);
                     next_s.s_err = s.s_seen;
                     next_s.p_err = pe && (rpar != (^rdat ^ pm));
                     next_s.f_err = !line;
                  end
               end
            end
         endcase
      end

      // Read data captured in the setup cycle
      if (psel && !penable) begin
         next_s.prdata = '0;
         unique case (paddr)
            ast_pkg::OFF_CMD: next_s.prdata[7:0] = s.cmd;
            ast_pkg::OFF_CTRL: next_s.prdata[7:0] = s.ctrl;
            ast_pkg::OFF_TXD: next_s.prdata[7:0] = s.tx_data;
            ast_pkg::OFF_TXS: begin
               next_s.prdata[ast_pkg::TXS_FULL] = s.tx_full;
               next_s.prdata[ast_pkg::TXS_BUSY] = s.tx_busy;
            end
            ast_pkg::OFF_RXD: next_s.prdata[7:0] = s.rx_data;
            ast_pkg::OFF_RXS: begin
               next_s.prdata[ast_pkg::RXS_FULL] = s.rx_full;
               next_s.prdata[ast_pkg::RXS_BUSY] = (s.rx_state != ast_pkg::RX_IDLE);
               next_s.prdata[ast_pkg::RXS_OERR] = s.o_err;
               next_s.prdata[ast_pkg::RXS_FERR] = s.f_err;
               next_s.prdata[ast_pkg::RXS_PERR] = s.p_err;
               next_s.prdata[ast_pkg::RXS_SERR] = s.s_err;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= ast_pkg::ST_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign tx_pin = s.tx_pin;
   assign irq_tx = s.irq_tx;
   assign irq_rx = s.irq_rx;

   // Checks
   property p_txfull_set;
      @(posedge core_clk) disable iff (rst)
      wr_txd |=> s.tx_full;
   endproperty
   a_txfull_set: assert property (p_txfull_set) else $error("tx full not set by write");

   property p_tx_fall_irq;
      @(posedge core_clk) disable iff (rst)
      $fell(s.tx_full) |-> s.irq_tx && s.tx_busy && s.tx_cnt == 12'h0;
   endproperty
   a_tx_fall_irq: assert property (p_tx_fall_irq) else $error("tx load without irq");

   property p_tx_load;
      @(posedge core_clk) disable iff (rst)
      s.irq_tx |-> $past(s.tx_full) && !$past(s.tx_busy) && s.tx_shift[0] == 1'b0;
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("tx load out of order");

   property p_tx_busy_hold;
      @(posedge core_clk) disable iff (rst)
      s.tx_busy && s.ctrl[ast_pkg::CTL_ENTX] && !tick |=> s.tx_busy;
   endproperty
   a_tx_busy_hold: assert property (p_tx_busy_hold) else $error("tx busy dropped");

   property p_rx_busy_start;
      @(posedge core_clk) disable iff (rst)
      s.rx_state == ast_pkg::RX_IDLE && s.ctrl[ast_pkg::CTL_ENRX] && !line
         |=> s.rx_state == ast_pkg::RX_START;
   endproperty
   a_rx_busy_start: assert property (p_rx_busy_start) else $error("start not seen");

   property p_rx_xfer;
      @(posedge core_clk) disable iff (rst)
      s.irq_rx |-> s.rx_full && s.rx_state == ast_pkg::RX_IDLE
         && $past(s.rx_state) == ast_pkg::RX_STOP;
   endproperty
   a_rx_xfer: assert property (p_rx_xfer) else $error("rx transfer mismatch");

   property p_overrun;
      @(posedge core_clk) disable iff (rst)
      s.irq_rx && $past(s.rx_full) && !$past(rd_rxd) |-> s.o_err;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_oerr_hold;
      @(posedge core_clk) disable iff (rst)
      s.o_err && !wr_rxs |=> s.o_err;
   endproperty
   a_oerr_hold: assert property (p_oerr_hold) else $error("overrun lost");

   property p_rd_clear;
      @(posedge core_clk) disable iff (rst)
      rd_rxd |=> !s.rx_full || s.irq_rx;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear full");

   property p_echo;
      @(posedge core_clk) disable iff (rst)
      $past(s.ctrl[ast_pkg::CTL_ECHO]) |-> s.tx_pin == ($past(s.rx_sync[1])
         ^ $past(s.ctrl[ast_pkg::CTL_XRX]) ^ $past(s.ctrl[ast_pkg::CTL_XTX]));
   endproperty
   a_echo: assert property (p_echo) else $error("echo path wrong");

   property p_tx_lsb_first;
      @(posedge core_clk) disable iff (rst)
      s.ctrl[ast_pkg::CTL_ENTX] && s.tx_busy && tick && s.tx_cnt == bit_len - 12'h1
         && s.tx_bits != 4'h0 |=> s.tx_shift[0] == $past(s.tx_shift[1]);
   endproperty
   a_tx_lsb_first: assert property (p_tx_lsb_first) else $error("tx order wrong");

   property p_tx_idle_pin;
      @(posedge core_clk) disable iff (rst)
      !$past(s.ctrl[ast_pkg::CTL_ECHO]) && !s.tx_busy
         |-> s.tx_pin == !$past(s.ctrl[ast_pkg::CTL_XTX]);
   endproperty
   a_tx_idle_pin: assert property (p_tx_idle_pin) else $error("tx idle level wrong");

   property p_tx_start_pin;
      @(posedge core_clk) disable iff (rst)
      s.irq_tx && !$past(s.ctrl[ast_pkg::CTL_ECHO])
         |-> s.tx_pin == $past(s.ctrl[ast_pkg::CTL_XTX]);
   endproperty
   a_tx_start_pin: assert property (p_tx_start_pin) else $error("no start bit");

   property p_tx_off;
      @(posedge core_clk) disable iff (rst)
      !s.ctrl[ast_pkg::CTL_ENTX] |=> !s.tx_busy;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("tx runs while disabled");

   property p_rx_off;
      @(posedge core_clk) disable iff (rst)
      !s.ctrl[ast_pkg::CTL_ENRX] |=> s.rx_state == ast_pkg::RX_IDLE;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("rx runs while disabled");

   property p_err_hold;
      @(posedge core_clk) disable iff (rst)
      !s.irq_rx |-> $stable(s.s_err) && $stable(s.p_err) && $stable(s.f_err);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag moved");

   property p_frame_err;
      @(posedge core_clk) disable iff (rst)
      s.irq_rx |-> s.f_err == !$past(line);
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("frame error wrong");

   property p_start_err;
      @(posedge core_clk) disable iff (rst)
      s.irq_rx |-> s.s_err == $past(s.s_seen);
   endproperty
   a_start_err: assert property (p_start_err) else $error("start error wrong");
endmodule
`default_nettype wire

// ---- sim/ast_remote_node.sv ----
// Remote serial node: drives the receive line, decodes the transmit line.
// Assumes the RC source at rate 111, 64 core clocks per bit.
`default_nettype none
module ast_remote_node #(parameter int BIT_CYC = 64) (
   input wire logic core_clk,
   input wire logic tx_line,
   output logic rx_line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rx_line = 1'h1;

   // Low start bit, then n bits LSB first, then idle high
   task automatic send(input logic [10:0] v, input int n);
      @(posedge core_clk) rx_line <= 1'h0;
      repeat (BIT_CYC) @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
         rx_line <= v[i];
         repeat (BIT_CYC) @(posedge core_clk);
      end
      rx_line <= 1'h1;
   endtask

   // Centre sampling after the start edge
   task automatic recv(input int n, output logic [10:0] v);
      v = '0;
      @(negedge tx_line);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
         repeat (BIT_CYC) @(posedge core_clk);
         v[i] = tx_line;
      end
   endtask

   task automatic level(input logic b);
      @(posedge core_clk) rx_line <= b;
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_async_serial_transceiver.sv ----
// Testbench for the serial transceiver: APB register tasks and a
// remote node model on the pins. Assumes 10 MHz core_clk.
`default_nettype none
module tb_async_serial_transceiver;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst, psel, penable, pwrite, rx_pin, xtal_clk;
   logic [7:0] paddr, d;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, tx_pin, irq_tx, irq_rx, e;
   logic [2:0] md;
   logic [10:0] v;
   int mismatches, n_tests, xc, t;
   logic [2:0] modes [5] = '{3'h1, 3'h7, 3'h3, 3'h6, 3'h0};
   logic [7:0] dat [5] = '{8'ha5, 8'h3c, 8'h81, 8'h7e, 8'hc3};

   ast_uart DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .xtal_clk(xtal_clk),
      .tx_pin(tx_pin), .irq_tx(irq_tx), .irq_rx(irq_rx));
   ast_remote_node node (.core_clk(core_clk), .tx_line(tx_pin), .rx_line(rx_pin));

   always #50 core_clk = ~core_clk;
   // Crystal stand-in: 306 core clocks per period
   always @(posedge core_clk) begin
      xc <= (xc == 152) ? 0 : xc + 1;
      if (xc == 152)
         xtal_clk <= ~xtal_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) begin
         @(posedge core_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      logic y;
      apb(1'h1, a, wd, x, y);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      logic y;
      apb(1'h0, a, 32'h0, x, y);
      check(x, exp);
      check({31'h0, y}, 32'h0);
   endtask

   task automatic wait_irq(input logic tx);
      int k;
      k = 0;
      while ((tx ? irq_tx : irq_rx) !== 1'h1 && k < 2000) begin
         k++;
         @(posedge core_clk);
      end
      check({31'h0, tx ? irq_tx : irq_rx}, 32'h1);
   endtask

   function automatic int nb(input logic [2:0] m);
      return 8 + int'(m[0]) + int'(m[1]);
   endfunction

   // Bits after the start bit; m is {odd, parity on, eight bits}
   function automatic logic [10:0] frame(input logic [7:0] x, input logic [2:0] m,
      input logic stp);
      logic [10:0] f;
      int k;
      f = {3'h0, m[0] ? x : {1'h0, x[6:0]}};
      k = 7 + int'(m[0]);
      if (m[1]) begin
         f[k] = ^f[7:0] ^ m[2];
         k++;
      end
      f[k] = stp;
      return f;
   endfunction

   task automatic rx_frame(input logic [10:0] f, input int n);
      fork
         node.send(f, n);
         wait_irq(1'h0);
      join
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge core_clk);
      mismatches++;
      complete_run();
   end

   initial begin
      core_clk = 1'h0;
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      xtal_clk = 1'h0;
      xc = 0;
      mismatches = 0;
      n_tests = 0;
      repeat (8) @(posedge core_clk);
      rst <= 1'h0;
      rdc(ast_pkg::OFF_CMD, 32'h1);
      rdc(ast_pkg::OFF_CTRL, 32'h5);
      rdc(ast_pkg::OFF_TXS, 32'h0);
      rdc(ast_pkg::OFF_RXS, 32'h0);
      apb(1'h0, 8'h18, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
      for (int m = 0; m < 5; m++) begin
         md = modes[m];
         d = dat[m];
         wr(ast_pkg::OFF_CTRL, 32'h47);
         wr(ast_pkg::OFF_CMD, {29'h0, md});
         wr(ast_pkg::OFF_TXD, {24'h0, d});
         rdc(ast_pkg::OFF_TXS, 32'h1);
         fork
            begin
               node.recv(nb(md), v);
               check({21'h0, v}, {21'h0, frame(d, md, 1'h1)});
               node.recv(nb(md), v);
               check({21'h0, v}, {21'h0, frame(~d, md, 1'h1)});
            end
            begin
               wr(ast_pkg::OFF_CTRL, 32'h67);
               wait_irq(1'h1);
               rdc(ast_pkg::OFF_TXS, 32'h2);
               wr(ast_pkg::OFF_TXD, {24'h0, ~d});
               rdc(ast_pkg::OFF_TXS, 32'h3);
            end
         join
         repeat (40) @(posedge core_clk);
         rdc(ast_pkg::OFF_TXS, 32'h0);
         fork
            rx_frame(frame(d, md, 1'h1), nb(md));
            begin
               repeat (100) @(posedge core_clk);
               rdc(ast_pkg::OFF_RXS, 32'h2);
            end
         join
         rdc(ast_pkg::OFF_RXS, 32'h1);
         rdc(ast_pkg::OFF_RXD, {24'h0, md[0] ? d : {1'h0, d[6:0]}});
         rdc(ast_pkg::OFF_RXS, 32'h0);
      end
      wr(ast_pkg::OFF_CMD, 32'h3);
      rx_frame(frame(8'h5a, 3'h3, 1'h1) ^ 11'h100, 10);
      rdc(ast_pkg::OFF_RXS, 32'h11);
      rdc(ast_pkg::OFF_RXD, 32'h5a);
      // One-cycle low glitch: start error, then an all-ones word
      node.level(1'h0);
      node.level(1'h1);
      wait_irq(1'h0);
      rdc(ast_pkg::OFF_RXS, 32'h31);
      rdc(ast_pkg::OFF_RXD, 32'hff);
      rx_frame(frame(8'h96, 3'h3, 1'h0), 10);
      wr(ast_pkg::OFF_CTRL, 32'h07);
      rdc(ast_pkg::OFF_RXS, 32'h9);
      rdc(ast_pkg::OFF_RXD, 32'h96);
      wr(ast_pkg::OFF_CTRL, 32'h47);
      rx_frame(frame(8'h11, 3'h3, 1'h1), 10);
      rx_frame(frame(8'h22, 3'h3, 1'h1), 10);
      rdc(ast_pkg::OFF_RXS, 32'h5);
      rdc(ast_pkg::OFF_RXD, 32'h22);
      rdc(ast_pkg::OFF_RXS, 32'h4);
      wr(ast_pkg::OFF_RXS, 32'h0);
      rdc(ast_pkg::OFF_RXS, 32'h0);
      wr(ast_pkg::OFF_CTRL, 32'h27);
      node.send(frame(8'h33, 3'h3, 1'h1), 10);
      rdc(ast_pkg::OFF_RXS, 32'h0);
      wr(ast_pkg::OFF_CTRL, 32'h0f);
      repeat (4) @(posedge core_clk);
      check({31'h0, tx_pin}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(ast_pkg::OFF_CTRL, {24'h0, 3'h4, i[2:1], 3'h7});
         node.level(i[0]);
         repeat (6) @(posedge core_clk);
         check({31'h0, tx_pin}, {31'h0, ^i[2:0]});
      end
      node.level(1'h1);
      wr(ast_pkg::OFF_CTRL, 32'h23);
      wr(ast_pkg::OFF_CMD, 32'h81);
      wr(ast_pkg::OFF_TXD, 32'h1);
      t = 0;
      while (tx_pin !== 1'h0 && t < 1000) begin
         t++;
         @(posedge core_clk);
      end
      t = 0;
      while (tx_pin === 1'h0 && t < 6000) begin
         t++;
         @(posedge core_clk);
      end
      // Start bit spans 14 crystal periods, first one possibly partial
      check({31'h0, t > 13 * 306 && t <= 14 * 306 + 4}, 32'h1);
      wr(ast_pkg::OFF_CTRL, 32'h03);
      complete_run();
   end
endmodule
`default_nettype wire
